/* File: rtl/adc_seq_regs.svh */
// Purpose: Offsets, field positions, reset values and counts for the converter sequencer
// Assumes: 32-bit AHB-Lite register words, 100 MHz hclk
// Notes:   Definitions only
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// Register byte offsets
`define CTRL_OFS        8'h00
`define STATUS_OFS      8'h04
`define READING_OFS     8'h08
`define SEGMENTS_OFS    8'h0c

// Control fields
`define CTRL_RUN_BIT    0
`define CTRL_RESET_VAL  32'h0000_0001

// Status fields
`define ST_PHASE_LSB    0
`define ST_POL_BIT      4
`define ST_OVR_BIT      5
`define ST_TEST_BIT     6
`define ST_HOLD_BIT     7

// Timing in oscillator periods and divided counts
`define OSC_DIV         4
`define BP_DIV          800
`define BP_HALF         400
`define CYCLE_COUNTS    4000
`define INT_COUNTS      1000
`define DEINT_MAX       2000
`define IOZ_MIN         11
`define IOZ_OVR_MIN     31
`define AZ_MIN          910
`define AZ_OVR_MIN      300
`define AZ_MAX          2900
`define AZ_OVR_MAX      910

`endif

/* File: rtl/adc_seq_pkg.sv */
// Purpose: Types shared by the converter sequencer
// Assumes: Nothing
// Notes:   Phase codes are one-hot
package adc_seq_pkg;

   typedef enum logic [3:0] {
      PH_IOZ   = 4'b0001,
      PH_AZ    = 4'b0010,
      PH_INT   = 4'b0100,
      PH_DEINT = 4'b1000
   } phase_e;

   typedef logic [15:0] bcd4_t;

endpackage

/* File: rtl/adc_sequencer.sv */
// Purpose: Dual-slope converter sequencer with static LCD drive and AHB-Lite registers
// Assumes: One clock hclk, oscillator period equals hclk period
// Notes:   Analog switches and comparator live outside this logic
//
// Notes on behaviour
// - Oscillator clock divided by four makes the count clock for all phases.
// - Counters are BCD decades so the count maps straight to digits; the phase and cycle counters here are binary.
// - Auto zero opens inputs, shorts nodes to common, closes offset loop.
// - Auto zero 910 to 2900 counts normally, 300 to 910 after over-range.
// - Leaving auto zero opens loop and connects inputs to external pair.
// - Signal integration lasts exactly 1000 counts.
// - Polarity is sampled from comparator at end of integration.
// - Reference connects opposite to latched input polarity during deintegration.
// - Deintegration runs up to 2000 counts until comparator zero crossing.
// - Result equals 1000 times input over reference.
// - 2000 counts is full scale; beyond it is over-range.
// - Integrator output zero lasts 11 to 640 counts.
// - Whole cycle is always 4000 counts.
// - Backplane is a square wave at oscillator over 800.
// - Segment in phase with backplane is off, antiphase is on.
// - Drive three digits, a leading one and minus when negative.
// - Test high turns all segments on steadily, showing -1888.
// - Hold high keeps converting but stops loading the display latch.
// - Hold defaults to updating when left open or low.
// - Output zero 11 to 140 normally, 31 to 640 after over-range.
// - Phase order: output zero, auto zero, integrate, deintegrate, repeat.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "adc_seq_regs.svh"

module adc_sequencer
   import adc_seq_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Pins
   input  wire logic        comparator_in,
   input  wire logic        reading_freeze_input,
   input  wire logic        test_input,
   // Analog switch controls
   output logic             az_loop_close,
   output logic             input_connect,
   output logic             ref_connect_pos,
   output logic             ref_connect_neg,
   output logic             int_zero_close,
   // LCD drive
   output logic [6:0]       units_segments,
   output logic [6:0]       tens_segments,
   output logic [6:0]       hundreds_segments,
   output logic             thousands_one_segments,
   output logic             minus_sign_segment,
   output logic             lcd_common_plane_drive
);

   // BCD increment of four digits
   function automatic bcd4_t bcd_inc(input bcd4_t v);
      bcd4_t r;
      logic  c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (c) begin
            if (r[i*4 +: 4] == 4'h9) begin
               r[i*4 +: 4] = 4'h0;
            end else begin
               r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // Seven-segment font, bits g f e d c b a
   function automatic logic [6:0] seg7(input logic [3:0] d);
      case (d)
         4'h0:    seg7 = 7'h3f;
         4'h1:    seg7 = 7'h06;
         4'h2:    seg7 = 7'h5b;
         4'h3:    seg7 = 7'h4f;
         4'h4:    seg7 = 7'h66;
         4'h5:    seg7 = 7'h6d;
         4'h6:    seg7 = 7'h7d;
         4'h7:    seg7 = 7'h07;
         4'h8:    seg7 = 7'h7f;
         4'h9:    seg7 = 7'h6f;
         default: seg7 = 7'h00;
      endcase
   endfunction

   // Input synchronisers
   logic [2:0] cmp_sync_r;
   logic [2:0] hold_sync_r;
   logic [2:0] test_sync_r;
   logic       cmp_r;
   logic       hold_r;
   logic       test_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_sync_r  <= 3'h0;
         hold_sync_r <= 3'h0;
         test_sync_r <= 3'h0;
      end else begin
         cmp_sync_r  <= {cmp_sync_r[1:0], comparator_in};
         hold_sync_r <= {hold_sync_r[1:0], reading_freeze_input};
         test_sync_r <= {test_sync_r[1:0], test_input};
      end
   end

   // Accept a change only once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_r  <= 1'b0;
         hold_r <= 1'b0;
         test_r <= 1'b0;
      end else begin
         if (cmp_sync_r[1] == cmp_sync_r[2]) begin
            cmp_r <= cmp_sync_r[2];
         end
         if (hold_sync_r[1] == hold_sync_r[2]) begin
            hold_r <= hold_sync_r[2];
         end
         if (test_sync_r[1] == test_sync_r[2]) begin
            test_r <= test_sync_r[2];
         end
      end
   end

   // Count clock tick: oscillator divided by four
   logic [1:0] div4_r;
   logic       tick;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div4_r <= 2'h0;
      end else begin
         div4_r <= div4_r + 2'h1;
      end
   end

   assign tick = (div4_r == 2'(`OSC_DIV - 1));

   // Run control from software
   logic ctrl_run_r;

   // Sequencer state
   phase_e      phase_r;
   logic [11:0] phase_cnt_r;
   logic [11:0] cycle_cnt_r;
   bcd4_t       deint_bcd_r;
   logic        pol_neg_r;
   logic        ovr_r;
   logic        last_ovr_r;
   logic        deint_done;
   logic [11:0] ioz_floor;

   // Comparator needs a count to settle after the reference is switched in
   assign deint_done = (!cmp_r && phase_cnt_r != 12'h000) ||
                       (phase_cnt_r == 12'(`DEINT_MAX - 1));

   // Output zero may not end before auto zero fits within its maximum
   assign ioz_floor = last_ovr_r ? 12'(`CYCLE_COUNTS - `AZ_OVR_MAX - 1) :
                                   12'(`CYCLE_COUNTS - `AZ_MAX - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r     <= PH_IOZ;
         phase_cnt_r <= 12'h000;
         cycle_cnt_r <= 12'(`CYCLE_COUNTS - `INT_COUNTS);
         deint_bcd_r <= 16'h0000;
         pol_neg_r   <= 1'b0;
         ovr_r       <= 1'b0;
         last_ovr_r  <= 1'b0;
      end else if (tick && ctrl_run_r) begin
         phase_cnt_r <= phase_cnt_r + 12'h001;
         // Cycle position wraps every 4000 counts; integration starts at zero
         if (cycle_cnt_r == 12'(`CYCLE_COUNTS - 1)) begin
            cycle_cnt_r <= 12'h000;
         end else begin
            cycle_cnt_r <= cycle_cnt_r + 12'h001;
         end
         case (phase_r)
            PH_IOZ: begin
               // at least 11 or 31 counts, rest goes to auto zero
               if (phase_cnt_r >= 12'((last_ovr_r ? `IOZ_OVR_MIN : `IOZ_MIN) - 1) &&
                   cycle_cnt_r >= ioz_floor) begin
                  phase_r     <= PH_AZ;
                  phase_cnt_r <= 12'h000;
               end
            end
            PH_AZ: begin
               // auto zero absorbs remainder so cycle is 4000
               if (cycle_cnt_r == 12'(`CYCLE_COUNTS - 1)) begin
                  phase_r     <= PH_INT;
                  phase_cnt_r <= 12'h000;
               end
            end
            PH_INT: begin
               if (phase_cnt_r == 12'(`INT_COUNTS - 1)) begin
                  phase_r     <= PH_DEINT;
                  phase_cnt_r <= 12'h000;
                  deint_bcd_r <= 16'h0000;
                  pol_neg_r   <= !cmp_r;
               end
            end
            PH_DEINT: begin
               deint_bcd_r <= bcd_inc(deint_bcd_r);
               if (deint_done) begin
                  phase_r     <= PH_IOZ;
                  phase_cnt_r <= 12'h000;
                  ovr_r       <= cmp_r;
                  last_ovr_r  <= cmp_r;
               end
            end
            default: begin
               phase_r     <= PH_IOZ;
               phase_cnt_r <= 12'h000;
            end
         endcase
      end
   end

   // Analog switch controls
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         az_loop_close   <= 1'b0;
         input_connect   <= 1'b0;
         ref_connect_pos <= 1'b0;
         ref_connect_neg <= 1'b0;
         int_zero_close  <= 1'b0;
      end else begin
         az_loop_close   <= (phase_r == PH_AZ);
         input_connect   <= (phase_r == PH_INT);
         ref_connect_pos <= (phase_r == PH_DEINT) && pol_neg_r;
         ref_connect_neg <= (phase_r == PH_DEINT) && !pol_neg_r;
         int_zero_close  <= (phase_r == PH_IOZ);
      end
   end

   // Display latch
   bcd4_t shown_r;
   logic  shown_neg_r;
   logic  shown_ovr_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shown_r     <= 16'h0000;
         shown_neg_r <= 1'b0;
         shown_ovr_r <= 1'b0;
      end else if (tick && ctrl_run_r && phase_r == PH_DEINT && deint_done && !hold_r) begin
         shown_r     <= deint_bcd_r;
         shown_neg_r <= pol_neg_r;
         shown_ovr_r <= cmp_r;
      end
   end

   // Backplane divider: toggles every 400 oscillator periods
   logic [8:0] bp_cnt_r;
   logic       bp_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bp_cnt_r <= 9'h000;
         bp_r     <= 1'b0;
      end else if (bp_cnt_r == 9'(`BP_HALF - 1)) begin
         bp_cnt_r <= 9'h000;
         bp_r     <= !bp_r;
      end else begin
         bp_cnt_r <= bp_cnt_r + 9'h001;
      end
   end

   // Segment patterns, 1 means lit
   logic [6:0] on_u;
   logic [6:0] on_t;
   logic [6:0] on_h;
   logic       on_k;
   logic       on_m;

   always_comb begin
      on_u = seg7(shown_r[3:0]);
      on_t = seg7(shown_r[7:4]);
      on_h = seg7(shown_r[11:8]);
      on_k = (shown_r[15:12] != 4'h0);
      on_m = shown_neg_r;
      if (shown_ovr_r) begin
         on_u = 7'h00;
         on_t = 7'h00;
         on_h = 7'h00;
         on_k = 1'b1;
      end
      if (test_r) begin
         on_u = 7'h7f;
         on_t = 7'h7f;
         on_h = 7'h7f;
         on_k = 1'b1;
         on_m = 1'b1;
      end
   end

   // Segment drivers: lit segments in antiphase; test mode holds steady DC
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         units_segments         <= 7'h00;
         tens_segments          <= 7'h00;
         hundreds_segments      <= 7'h00;
         thousands_one_segments <= 1'b0;
         minus_sign_segment     <= 1'b0;
         lcd_common_plane_drive <= 1'b0;
      end else if (test_r) begin
         units_segments         <= on_u;
         tens_segments          <= on_t;
         hundreds_segments      <= on_h;
         thousands_one_segments <= on_k;
         minus_sign_segment     <= on_m;
         lcd_common_plane_drive <= 1'b0;
      end else begin
         units_segments         <= on_u ^ {7{bp_r}};
         tens_segments          <= on_t ^ {7{bp_r}};
         hundreds_segments      <= on_h ^ {7{bp_r}};
         thousands_one_segments <= on_k ^ bp_r;
         minus_sign_segment     <= on_m ^ bp_r;
         lcd_common_plane_drive <= bp_r;
      end
   end

   // AHB-Lite slave
   logic       ap_valid_r;
   logic       ap_write_r;
   logic [7:0] ap_addr_r;
   logic       take;

   assign take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r  <= 8'h00;
      end else if (hready) begin
         ap_valid_r <= take;
         ap_write_r <= hwrite;
         ap_addr_r  <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_run_r <= 1'(`CTRL_RESET_VAL >> `CTRL_RUN_BIT);
      end else if (ap_valid_r && ap_write_r && ap_addr_r == `CTRL_OFS) begin
         ctrl_run_r <= hwdata[`CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         if (take && !hwrite) begin
            case (haddr)
               `CTRL_OFS:     hrdata <= {31'h0, ctrl_run_r};
               `STATUS_OFS:   hrdata <= {24'h0, hold_r, test_r, ovr_r, pol_neg_r, phase_r};
               `READING_OFS:  hrdata <= {14'h0, shown_ovr_r, shown_neg_r, shown_r};
               `SEGMENTS_OFS: hrdata <= {8'h0, lcd_common_plane_drive, minus_sign_segment,
                                         thousands_one_segments, hundreds_segments,
                                         tens_segments, units_segments};
               default:       hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

/* File: test/adc_seq_checker_asserts.sv */
// Purpose: Port checks for the converter sequencer
// Assumes: hclk is one oscillator period
// Notes:   Bound at the foot
`timescale 1ns/100ps
module adc_seq_checker (
   // Clock, reset and test pin
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       test_input,
   // Switch controls and LCD drive
   input wire logic       az_loop_close,
   input wire logic       input_connect,
   input wire logic       ref_connect_pos,
   input wire logic       ref_connect_neg,
   input wire logic       int_zero_close,
   input wire logic [6:0] units_segments,
   input wire logic       lcd_common_plane_drive
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0]  ph;
   logic [15:0] len_r [4];
   logic [15:0] cyc_r;
   logic [9:0]  bpc_r;
   logic        cok_r;
   logic        bok_r;
   // Phases: output zero, auto zero, integrate, deintegrate
   assign ph = {ref_connect_pos | ref_connect_neg, input_connect, az_loop_close,
                int_zero_close};
   // Phase lengths, cycle length and backplane spacing in hclk periods
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         len_r <= '{default: 16'h0};
         cyc_r <= 16'h0;
         bpc_r <= 10'h0;
         cok_r <= 1'b0;
         bok_r <= 1'b0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            len_r[i] <= ph[i] ? len_r[i] + 16'h1 : 16'h0;
         end
         cyc_r <= $rose(ph[2]) ? 16'h1 : cyc_r + 16'h1;
         cok_r <= cok_r | $rose(ph[2]);
         bpc_r <= $changed(lcd_common_plane_drive) ? 10'h0 : bpc_r + 10'h1;
         bok_r <= !test_input & (bok_r | $changed(lcd_common_plane_drive));
      end
   end
   property p_bp;
      bok_r && !test_input |-> $changed(lcd_common_plane_drive) == (bpc_r == 10'h18f);
   endproperty
   a_bp: assert property (p_bp) else $error("backplane half period wrong");
   property p_test;
      test_input [*8] |-> ((units_segments ^ {7{lcd_common_plane_drive}}) == 7'h7f)
         && $stable(units_segments);
   endproperty
   a_test: assert property (p_test) else $error("test mode not all lit");
   property p_one;
      $onehot0({ph, ref_connect_pos & ref_connect_neg});
   endproperty
   a_one: assert property (p_one) else $error("switch phases overlap");
   property p_ioz;
      $fell(ph[0]) |-> ph[1] && len_r[0] >= 16'h2c && len_r[0] <= 16'ha00;
   endproperty
   a_ioz: assert property (p_ioz) else $error("output zero length");
   property p_az;
      $fell(ph[1]) |-> ph[2] && len_r[1] >= 16'h4b0 && len_r[1] <= 16'h2d50;
   endproperty
   a_az: assert property (p_az) else $error("auto zero length");
   property p_int;
      $fell(ph[2]) |-> ph[3] && len_r[2] == 16'hfa0;
   endproperty
   a_int: assert property (p_int) else $error("integrate length");
   property p_deint;
      ph[3] |-> len_r[3] < 16'h1f40;
   endproperty
   a_deint: assert property (p_deint) else $error("deintegrate too long");
   property p_cycle;
      $rose(ph[2]) && cok_r |-> cyc_r == 16'h3e80;
   endproperty
   a_cycle: assert property (p_cycle) else $error("cycle length wrong");
   cover property ($fell(ref_connect_pos));
   cover property ($fell(ref_connect_neg));
   cover property (test_input [*8]);
endmodule

bind adc_sequencer adc_seq_checker i_chk (.hclk, .hresetn, .test_input, .az_loop_close,
   .input_connect, .ref_connect_pos, .ref_connect_neg, .int_zero_close, .units_segments,
   .lcd_common_plane_drive);

/* File: test/lcd_panel_model.sv */
// Purpose: Integrator, comparator and LCD panel facing the sequencer
// Assumes: Input in reading counts, reference worth 1000 counts
// Notes:   Lit segment is drive XOR backplane
`timescale 1ns/100ps
module lcd_panel_model (
   // Clock and stimulus
   input  wire logic        hclk,
   input  wire logic [31:0] vin,
   // Switch controls
   input  wire logic        az_loop_close,
   input  wire logic        input_connect,
   input  wire logic        ref_connect_pos,
   input  wire logic        ref_connect_neg,
   input  wire logic        int_zero_close,
   output logic             comparator_in,
   // Panel
   input  wire logic [6:0]  units_segments,
   input  wire logic        thousands_one_segments,
   input  wire logic        minus_sign_segment,
   input  wire logic        lcd_common_plane_drive,
   output logic [8:0]       lit
);
   int acc = 0;
   always @(posedge hclk) begin
      if (az_loop_close || int_zero_close) begin
         acc <= 0;
      end else if (input_connect) begin
         acc <= acc + $signed(vin);
      end else if (ref_connect_pos) begin
         acc <= (acc > -1000) ? 0 : acc + 1000;
      end else if (ref_connect_neg) begin
         acc <= (acc < 1000) ? 0 : acc - 1000;
      end
   end
   // High while the integrator has not come back to zero
   assign comparator_in = ref_connect_pos ? (acc < 0) : (acc > 0);
   assign lit = {minus_sign_segment, thousands_one_segments, units_segments}
                ^ {9{lcd_common_plane_drive}};
endmodule

/* File: test/testbench.sv */
// Purpose: Directed tests of the converter sequencer over AHB-Lite
// Assumes: Panel model scaled so a reading equals the input in counts
// Notes:   Readings allow one count of comparator sync lag
`timescale 1ns/100ps
`include "adc_seq_regs.svh"
module testbench;
   localparam logic [6:0] FONT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                        7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        reading_freeze_input = 1'b0;
   logic        test_input = 1'b0;
   logic [31:0] vin = 32'h0;
   logic [31:0] hrdata, rd;
   logic [6:0]  units_segments, tens_segments, hundreds_segments;
   logic [8:0]  lit;
   logic        hreadyout, comparator_in, az_loop_close, input_connect, ref_connect_pos;
   logic        ref_connect_neg, int_zero_close, thousands_one_segments;
   logic        minus_sign_segment, lcd_common_plane_drive, hresp;
   int          failures = 0;
   int          n_compared = 0;

   always #5 hclk = ~hclk;

   adc_sequencer i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .comparator_in,
      .reading_freeze_input, .test_input, .az_loop_close, .input_connect,
      .ref_connect_pos, .ref_connect_neg, .int_zero_close, .units_segments,
      .tens_segments, .hundreds_segments, .thousands_one_segments,
      .minus_sign_segment, .lcd_common_plane_drive);

   lcd_panel_model i_panel (.hclk, .vin, .az_loop_close, .input_connect,
      .ref_connect_pos, .ref_connect_neg, .int_zero_close, .comparator_in,
      .units_segments, .thousands_one_segments, .minus_sign_segment,
      .lcd_common_plane_drive, .lit);

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check(32'(hresp), 32'h0, "hresp");
   endtask

   // Run one full cycle with input v and check the shown reading e
   task automatic convert(input int v, input int e);
      int   got;
      int   mag;
      logic ovr;
      logic [13:0] hd;
      vin <= v;
      @(posedge int_zero_close);
      repeat (20) @(posedge hclk);
      mag = (e < 0) ? -e : e;
      ovr = mag > 1999;
      ahb(1'b0, `READING_OFS, 32'h0);
      got = rd[15:12] * 1000 + rd[11:8] * 100 + rd[7:4] * 10 + rd[3:0];
      check(32'(rd[3:0] > 9 || rd[7:4] > 9 || rd[11:8] > 9), 32'h0, "bcd");
      check(32'(rd[17:16]), 32'({ovr, e < 0}), "flags");
      if (!ovr) check(32'(got > mag + 1 || got < mag - 1), 32'h0, "value");
      check(32'(lit), 32'({e < 0, ovr || mag > 999, ovr ? 7'h0 : FONT[got % 10]}),
            "lit");
      hd = {hundreds_segments, tens_segments} ^ {14{lcd_common_plane_drive}};
      check(32'(hd), 32'(ovr ? 14'h0 : {FONT[got/100%10], FONT[got/10%10]}), "dig");
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, `CTRL_OFS, 32'h0);
      check(rd, `CTRL_RESET_VAL, "ctrl reset");
      ahb(1'b1, 8'h10, 32'hffff_ffff);
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0, "unmapped");
      ahb(1'b1, `CTRL_OFS, 32'h1);
      convert(1234, 1234);
      reading_freeze_input <= 1'b1;
      convert(-452, 1234);
      reading_freeze_input <= 1'b0;
      convert(-452, -452);
      convert(2500, 2000);
      ahb(1'b0, `STATUS_OFS, 32'h0);
      check(rd, 32'((1 << `ST_OVR_BIT) | 1), "status");
      test_input <= 1'b1;
      repeat (20) @(posedge hclk);
      check(32'(lit), 32'h1ff, "test lit");
      rd = {24'h0, units_segments, lcd_common_plane_drive};
      repeat (500) @(posedge hclk);
      check({24'h0, units_segments, lcd_common_plane_drive}, rd, "test steady");
      test_input <= 1'b0;
      tally_and_finish();
   end

   initial begin
      #1_000_000;
      failures++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
